//--- include/timer_pkg.sv
// constants, modes and state types of the reloadable timer
package timer_pkg;

    // apb register byte offsets
    localparam logic [7:0] ctrl_off   = 8'h00;
    localparam logic [7:0] count_off  = 8'h04;
    localparam logic [7:0] reload_off = 8'h08;
    localparam logic [7:0] status_off = 8'h0c;

    // control field positions
    localparam int ctrl_enable_bit = 0;
    localparam int ctrl_mode_lsb   = 1;
    localparam int ctrl_pol_bit    = 3;
    localparam int ctrl_outen_bit  = 4;
    localparam int ctrl_pre_lsb    = 8;

    // count and prescale values
    localparam logic [15:0] count_restart  = 16'h0001;
    localparam logic [15:0] count_reset    = 16'h0000;
    localparam logic [15:0] reload_reset   = 16'h0000;
    localparam logic [7:0]  prescale_reset = 8'h01;
    localparam int          prescale_max   = 128;

    // operating modes
    typedef enum logic [1:0] {
        mode_one_shot   = 2'b00,
        mode_continuous = 2'b01,
        mode_counter    = 2'b10,
        mode_comparator = 2'b11
    } mode_e;

    // software controls
    typedef struct packed {
        logic        enable;
        mode_e       mode;
        logic        output_polarity_edge_select;
        logic        out_enable;
        logic [7:0]  prescale;
    } ctrl_s;

    // whole block state
    typedef struct packed {
        ctrl_s       ctrl;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0]  div_cnt;
        logic        in_prev;
        logic        out_level;
        logic        out_pulse;
        logic        out_pin;
        logic        irq;
        logic        reload_seen;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } state_s;

endpackage : timer_pkg

//--- core/reloadable_timer_16bit.sv
// reloadable 16-bit timer with prescaler, four modes and apb registers
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RL1] count is a 16-bit up-counter
// [RL2] prescaler divides system clock by 1 to 128
// [RL3] count wraps from ffff to 0000 and keeps going
// [RL4] reload 0000 means full 65536 range; 0001 shortest
// [RL5] one-shot reload: interrupt, count to 0001, clear enable, stop
// [RL6] one-shot with output on: pin inverted for one clock
// [RL7] software flips polarity after start for a lasting level change
// [RL8] one-shot and continuous count prescaled clock only
// [RL9] continuous reload: interrupt, count to 0001, keep counting
// [RL10] continuous and counter modes toggle output at each reload
// [RL11] start count only affects first pass; later passes start 0001
// [RL12] counter mode counts input pin edges, prescaler bypassed
// [RL13] polarity selects counted edge in counter modes
// [RL14] polarity sets initial output level in counter modes
// [RL15] counted signals toggle no faster than quarter clock
// [RL16] counter mode reload: interrupt, count to 0001, continue
// [RL17] comparator mode counts comparator edges, reload like counter
// [RL18] software loads count 0001 before counter modes
// [RL19] software disables before configuring, enables last
// [RL20] prescale counter cleared while disabled
// [RL21] reload interrupt is a one-clock pulse
module reloadable_timer_16bit
    import timer_pkg::*;
#(
    parameter int prescale_limit = prescale_max
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // counted sources
    input  wire logic        timer_in,
    input  wire logic        comparator_out,
    // timer outputs
    output var  logic        timer_out,
    output var  logic        timer_irq
);

    // elaboration check on prescale range
    if (prescale_limit < 1 || prescale_limit > prescale_max) begin : g_check
        $error("prescale_limit out of range");
    end

    state_s st;
    state_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // combinational next state
    logic        src_sel;
    logic        edge_hit;
    logic        tick;
    logic        at_reload;
    logic [7:0]  pre_eff;
    logic        wr_acc;
    logic        rd_acc;

    always_comb begin
        next_st = st;
        next_st.irq = 1'b0; // [RL21]
        next_st.out_pulse = 1'b0;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.in_prev = (st.ctrl.mode == mode_comparator) ? comparator_out : timer_in;

        // edge detection on the selected source
        src_sel = (st.ctrl.mode == mode_comparator) ? comparator_out : timer_in; // [RL17]
        edge_hit = st.ctrl.output_polarity_edge_select ? (src_sel & ~st.in_prev)
                                                       : (~src_sel & st.in_prev); // [RL13]

        // prescale value of zero treated as one
        pre_eff = (st.ctrl.prescale == 8'h00) ? prescale_reset : st.ctrl.prescale;
        tick = 1'b0;
        if (st.ctrl.enable) begin
            unique case (st.ctrl.mode)
                mode_one_shot, mode_continuous: begin
                    // prescaled system clock only
                    if (st.div_cnt + 8'h01 >= pre_eff) begin // [RL2] [RL8]
                        tick = 1'b1;
                        next_st.div_cnt = 8'h00;
                    end else begin
                        next_st.div_cnt = st.div_cnt + 8'h01;
                    end
                end
                mode_counter, mode_comparator: begin
                    tick = edge_hit; // [RL12]
                    next_st.div_cnt = 8'h00;
                end
            endcase
        end else begin
            next_st.div_cnt = 8'h00; // [RL20]
        end

        // reload of zero matches after wrap through ffff to 0000
        at_reload = (st.count == st.reload); // [RL4]
        if (tick) begin
            if (at_reload) begin
                next_st.count = count_restart; // [RL5] [RL9] [RL11] [RL16] [RL17]
                next_st.irq = 1'b1;
                next_st.reload_seen = 1'b1;
                if (st.ctrl.mode == mode_one_shot) begin
                    next_st.ctrl.enable = 1'b0; // [RL5]
                    // polarity flipped after start: lasting change, else a pulse
                    if (st.ctrl.out_enable) begin
                        if (st.ctrl.output_polarity_edge_select != st.out_level) begin
                            next_st.out_level = st.ctrl.output_polarity_edge_select; // [RL7]
                        end else begin
                            next_st.out_pulse = 1'b1; // [RL6]
                        end
                    end
                end else if (st.ctrl.out_enable) begin
                    next_st.out_level = ~st.out_level; // [RL10]
                end
            end else begin
                next_st.count = st.count + 16'h0001; // [RL1] [RL3]
            end
        end

        // apb register access, pready answers one cycle after the access phase starts
        wr_acc = psel & penable & pwrite & ~st.pready;
        rd_acc = psel & penable & ~pwrite & ~st.pready;
        if (psel & penable & ~st.pready) begin
            next_st.pready = 1'b1;
        end
        if (wr_acc) begin
            unique case (paddr)
                ctrl_off: begin
                    next_st.ctrl.enable = pwdata[ctrl_enable_bit];
                    next_st.ctrl.mode = mode_e'(pwdata[ctrl_mode_lsb +: 2]);
                    next_st.ctrl.output_polarity_edge_select = pwdata[ctrl_pol_bit];
                    next_st.ctrl.out_enable = pwdata[ctrl_outen_bit];
                    next_st.ctrl.prescale = pwdata[ctrl_pre_lsb +: 8];
                    // polarity sets output level while configuring
                    if (!pwdata[ctrl_enable_bit]) begin
                        next_st.out_level = pwdata[ctrl_pol_bit]; // [RL14]
                    end
                end
                count_off:  next_st.count = pwdata[15:0];
                reload_off: next_st.reload = pwdata[15:0];
                // a reload in the same cycle as the clear wins
                status_off: next_st.reload_seen = (st.reload_seen & ~pwdata[0])
                                                  | (tick & at_reload);
                default:    next_st.pslverr = 1'b1;
            endcase
        end
        if (rd_acc) begin
            unique case (paddr)
                ctrl_off: next_st.prdata = {16'h0000, st.ctrl.prescale, 3'h0,
                                            st.ctrl.out_enable,
                                            st.ctrl.output_polarity_edge_select,
                                            st.ctrl.mode, st.ctrl.enable};
                count_off:  next_st.prdata = {16'h0000, st.count};
                reload_off: next_st.prdata = {16'h0000, st.reload};
                status_off: next_st.prdata = {30'h0, st.out_level, st.reload_seen};
                default: begin
                    next_st.prdata = 32'h0000_0000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        // clamp prescale to the supported limit
        if (next_st.ctrl.prescale > 8'(prescale_limit)) begin
            next_st.ctrl.prescale = 8'(prescale_limit);
        end
        // pin level held in its own flop so the output has no gate behind it
        next_st.out_pin = next_st.out_level ^ next_st.out_pulse; // [RL6] [RL10]
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl.prescale <= prescale_reset;
            st.count <= count_reset;
            st.reload <= reload_reset;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign timer_out = st.out_pin; // [RL6]
    assign timer_irq = st.irq;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    irq_one_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        timer_irq |=> !timer_irq) else $error("irq longer than one cycle"); // [RL21]

    restart_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(timer_irq) |-> st.count == count_restart) // [RL9]
        else $error("count not 0001 after reload");

    one_shot_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_irq && st.ctrl.mode == mode_one_shot && !$past(wr_acc))
        |-> !st.ctrl.enable) else $error("one-shot did not stop"); // [RL5]

    pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.out_pulse |=> !st.out_pulse) else $error("output pulse too long"); // [RL6]

    disabled_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.ctrl.enable && !wr_acc) |=> st.count == $past(st.count))
        else $error("count moved while disabled"); // [RL1]

    div_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st.ctrl.enable |=> st.div_cnt == 8'h00 || $past(wr_acc))
        else $error("prescaler not cleared"); // [RL20]

    up_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !at_reload && !wr_acc) |=> st.count == $past(st.count) + 16'h0001)
        else $error("count did not step up"); // [RL3]

    toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload && st.ctrl.out_enable && st.ctrl.mode != mode_one_shot
         && !wr_acc) |=> st.out_level != $past(st.out_level))
        else $error("output did not toggle"); // [RL10]

    counter_edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.enable && st.ctrl.mode == mode_counter && !edge_hit && !wr_acc)
        |=> st.count == $past(st.count)) else $error("count without edge"); // [RL12]

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready) else $error("apb no answer");

    apb_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("apb answer longer than one cycle");

    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && paddr != ctrl_off && paddr != count_off
         && paddr != reload_off && paddr != status_off) |=> pslverr)
        else $error("unmapped access not refused");

    ////////////////////////////////////////////////////////////////////////
    // reload event checks
    irq_on_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload) |=> timer_irq) else $error("reload without irq"); // [RL21]

    seen_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload) |=> st.reload_seen) else $error("reload flag lost"); // [RL9]

    seen_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == status_off && pwdata[0] && !(tick && at_reload))
        |=> !st.reload_seen) else $error("reload flag not cleared");

    restart_after_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload && !wr_acc) |=> st.count == count_restart)
        else $error("pass did not restart at 0001"); // [RL11]

    continuous_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload && st.ctrl.mode != mode_one_shot && !wr_acc)
        |=> st.ctrl.enable) else $error("repeating mode stopped"); // [RL9]

    counter_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload && st.ctrl.mode == mode_counter && !wr_acc)
        |=> timer_irq && st.ctrl.enable) else $error("counter reload wrong"); // [RL16]

    disabled_no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st.ctrl.enable |=> !timer_irq) else $error("irq while disabled"); // [RL5]

    ////////////////////////////////////////////////////////////////////////
    // output pin checks
    one_shot_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload && st.ctrl.mode == mode_one_shot && st.ctrl.out_enable
         && st.ctrl.output_polarity_edge_select == st.out_level && !wr_acc)
        |=> st.out_pulse) else $error("one-shot pulse missing"); // [RL6]

    lasting_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && at_reload && st.ctrl.mode == mode_one_shot && st.ctrl.out_enable
         && st.ctrl.output_polarity_edge_select != st.out_level && !wr_acc)
        |=> st.out_level != $past(st.out_level)) else $error("no lasting change"); // [RL7]

    level_from_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == ctrl_off && !pwdata[ctrl_enable_bit])
        |=> st.out_level == $past(pwdata[ctrl_pol_bit]))
        else $error("output level not set by polarity"); // [RL14]

    ////////////////////////////////////////////////////////////////////////
    // counting source checks
    wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !at_reload && st.count == 16'hffff && !wr_acc)
        |=> st.count == 16'h0000) else $error("no wrap to 0000"); // [RL3]

    full_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && st.reload == 16'h0000 && st.count == 16'hffff && !wr_acc)
        |=> st.count == 16'h0000 && !timer_irq) else $error("reload zero cut short"); // [RL4]

    prescale_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.ctrl.prescale <= 8'(prescale_limit)) else $error("prescale above limit"); // [RL2]

    prescaled_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.enable && (st.ctrl.mode == mode_one_shot || st.ctrl.mode == mode_continuous)
         && st.div_cnt + 8'h01 < pre_eff && !wr_acc)
        |=> st.count == $past(st.count)) else $error("count between ticks"); // [RL8]

    rising_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.enable && st.ctrl.mode == mode_counter && st.ctrl.output_polarity_edge_select
         && timer_in && !st.in_prev && !at_reload && !wr_acc)
        |=> st.count == $past(st.count) + 16'h0001) else $error("edge missed"); // [RL13]

    comparator_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.enable && st.ctrl.mode == mode_comparator && comparator_out == st.in_prev
         && !wr_acc) |=> st.count == $past(st.count))
        else $error("comparator count without edge"); // [RL17]

    cover_one_shot_c: cover property (@(posedge pclk)
        timer_irq && st.ctrl.mode == mode_one_shot);
    cover_continuous_c: cover property (@(posedge pclk)
        timer_irq && st.ctrl.mode == mode_continuous);
    cover_counter_c: cover property (@(posedge pclk)
        timer_irq && st.ctrl.mode == mode_counter);
    cover_comparator_c: cover property (@(posedge pclk)
        timer_irq && st.ctrl.mode == mode_comparator);

endmodule : reloadable_timer_16bit

`default_nettype wire

//--- tb/source_model.sv
// model of the counted sources: timer input pin and comparator output
`timescale 1ns/100ps
`default_nettype none
module source_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // which sources toggle: bit 0 input pin, bit 1 comparator
    input  wire logic [1:0] run,
    // counted sources
    output var  logic       timer_in,
    output var  logic       comparator_out
);
    logic [1:0] div;
    // toggle every four clocks, at a quarter of the clock rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div            <= 2'h0;
            timer_in       <= 1'b0;
            comparator_out <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3 && run[0]) timer_in <= !timer_in;
            if (div == 2'h3 && run[1]) comparator_out <= !comparator_out;
        end
    end
endmodule : source_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the reloadable timer over apb
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import timer_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, e_bit, timer_in, comparator_out;
    logic        timer_out, timer_irq;
    logic [1:0]  run;
    int          err_total, num_checks, cycles, n, e, h;
    int          ps[3] = '{1, 4, 128};

    reloadable_timer_16bit reloadable_timer_16bit_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
        .comparator_out(comparator_out), .timer_out(timer_out), .timer_irq(timer_irq));
    source_model source_model_inst (.pclk(pclk), .presetn(presetn), .run(run),
        .timer_in(timer_in), .comparator_out(comparator_out));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 100000) begin
            err_total++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // report, compare and bus tasks
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e_bit = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // disable, program mode, start count and reload, then enable last
    task automatic cfg(input logic [1:0] m, input logic pl, input logic oe,
                       input logic [7:0] p, input logic [15:0] c, input logic [15:0] r);
        logic [31:0] cw;
        cw = {16'h0, p, 3'h0, oe, pl, m, 1'b0};
        apb(ctrl_off, 1'b1, cw);
        apb(count_off, 1'b1, {16'h0, c});
        apb(reload_off, 1'b1, {16'h0, r});
        apb(ctrl_off, 1'b1, cw | 32'h1);
    endtask : cfg
    // cycles to the next interrupt, counting rising pin and falling comparator edges
    task automatic wait_irq();
        logic pi;
        logic pc;
        n = 0;
        e = 0;
        pi = timer_in;
        pc = comparator_out;
        do begin
            @(posedge pclk);
            #1;
            n++;
            e += int'(timer_in & !pi) + int'(!comparator_out & pc);
            pi = timer_in;
            pc = comparator_out;
        end while (timer_irq !== 1'b1);
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, run} = '0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(ctrl_off, 1'b0, 32'h0);
        check(q, 32'h0000_0100);
        apb(8'h10, 1'b0, 32'h0);
        check({31'h0, e_bit}, 32'h1);
        // continuous, pin toggling meanwhile, three prescale values
        run <= 2'b01;
        foreach (ps[i]) begin
            cfg(mode_continuous, 1'b0, 1'b1, 8'(ps[i]), 16'h0002, 16'h0003);
            wait_irq();
            h = int'(timer_out);
            wait_irq();
            check(n, 3 * ps[i]);
            check({31'h0, timer_out}, {31'h0, !h[0]});
            @(posedge pclk);
            #1;
            check({31'h0, timer_irq}, 32'h0);
        end
        run <= 2'b00;
        // one-shot across the wrap, output pulse and self-disable
        cfg(mode_one_shot, 1'b0, 1'b1, 8'h01, 16'hffff, 16'h0001);
        wait_irq();
        check({31'h0, n < 8}, 32'h1);
        h = int'(timer_out);
        repeat (3) begin
            @(posedge pclk);
            #1;
            h += int'(timer_out);
        end
        check(h, 1);
        apb(ctrl_off, 1'b0, 32'h0);
        check({31'h0, q[0]}, 32'h0);
        apb(count_off, 1'b0, 32'h0);
        check(q, 32'h1);
        // reload zero gives the full range
        cfg(mode_one_shot, 1'b0, 1'b0, 8'h01, 16'h0001, 16'h0000);
        wait_irq();
        check({31'h0, n > 65530 && n < 65540}, 32'h1);
        // counter mode on rising pin edges
        cfg(mode_counter, 1'b1, 1'b1, 8'h01, 16'h0001, 16'h0004);
        check({31'h0, timer_out}, 32'h1);
        run <= 2'b01;
        wait_irq();
        check(e, 4);
        wait_irq();
        check(e, 4);
        run <= 2'b00;
        // comparator mode on falling edges
        cfg(mode_comparator, 1'b0, 1'b0, 8'h01, 16'h0001, 16'h0002);
        check({31'h0, timer_out}, 32'h0);
        run <= 2'b10;
        wait_irq();
        check(e, 2);
        run <= 2'b00;
        // lasting level change: polarity flipped after the one-shot starts
        cfg(mode_one_shot, 1'b0, 1'b1, 8'h01, 16'h0001, 16'h0040);
        apb(ctrl_off, 1'b1, 32'h0000_0119);
        wait_irq();
        repeat (3) @(posedge pclk);
        #1;
        check({31'h0, timer_out}, 32'h1);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
